// ===== src/ops_pkg.sv
// Package of constants and types for the off-line converter sequencer.
package ops_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_HZ             = 100_000_000;
   localparam int unsigned FREQ_LOW_HZ        = 60_000;
   localparam int unsigned FREQ_HIGH_HZ       = 115_000;
   localparam int unsigned JITTER_LOW_HZ      = 4_000;
   localparam int unsigned JITTER_HIGH_HZ     = 8_000;
   localparam int unsigned JITTER_RATE_HZ     = 230;
   localparam int unsigned OVERLOAD_TRIP_MS   = 50;
   localparam int unsigned RESTART_TIME_MS    = 1_000;
   localparam int unsigned SOFT_START_US      = 8_500;
   localparam int unsigned SS_STEPS           = 16;

   // Period in cycles at nominal and at plus/minus jitter extremes
   localparam int unsigned PER_LOW            = CLK_HZ / FREQ_LOW_HZ;
   localparam int unsigned PER_HIGH           = CLK_HZ / FREQ_HIGH_HZ;
   localparam int unsigned DEV_LOW            =
      CLK_HZ / (FREQ_LOW_HZ - JITTER_LOW_HZ) - PER_LOW;
   localparam int unsigned DEV_HIGH           =
      CLK_HZ / (FREQ_HIGH_HZ - JITTER_HIGH_HZ) - PER_HIGH;
   // Cycles per jitter triangle step (64 steps per modulation period)
   localparam int unsigned JIT_STEP_CYC       = CLK_HZ / (JITTER_RATE_HZ * 64);
   // Overload trip counts in switching cycles
   localparam int unsigned OVL_CNT_LOW        = FREQ_LOW_HZ * OVERLOAD_TRIP_MS / 1000;
   localparam int unsigned OVL_CNT_HIGH       = FREQ_HIGH_HZ * OVERLOAD_TRIP_MS / 1000;
   localparam int unsigned RESTART_CYC        = CLK_HZ / 1000 * RESTART_TIME_MS;
   localparam int unsigned SS_STEP_CYC        = CLK_HZ / 1_000_000 * SOFT_START_US / SS_STEPS;

   // ==========================================================
   // Current levels, 8-bit codes of drain current
   // ==========================================================
   localparam logic [7:0]  CAP_DEFAULT        = 8'h46;   // Full default limit
   localparam logic [7:0]  BURST_CURRENT_CAP  = 8'h0F;   // Reduced burst limit
   localparam logic [7:0]  SS_START_CAP       = 8'h04;   // First soft-start step
   localparam logic [7:0]  COMP_INT_REF       = 8'hA0;   // Internal compensation ref

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      OPS_OFF,
      OPS_CHARGE,
      OPS_RUN,
      OPS_RESTART_WAIT
   } ops_state_type;

   typedef struct packed {
      logic       bulk_ok;         // Bulk above drain start threshold
      logic       above_on;        // Supply above turn-on level
      logic       above_cs_on;     // Supply above charger enable level
      logic       above_off;       // Supply above turn-off level
   } ops_supply_type;

   typedef struct packed {
      logic       pwm_trip;        // Sensed current reached COMP level
      logic       oc_trip;         // Overcurrent comparator tripped
      logic       comp_low;        // COMP below burst enter threshold
      logic       comp_high;       // COMP above burst exit (thr + hyst)
      logic       comp_sat;        // COMP above upper saturation
      logic       fb_grounded;     // Feedback pin shorted to ground
   } ops_sense_type;

endpackage : ops_pkg

// ===== src/ops_osc.sv
// Jittered fixed-frequency oscillator producing a cycle-start pulse.
`timescale 1ns/1ns
module ops_osc
   import ops_pkg::*;
(
   input  wire logic  sys_clk,
   input  wire logic  reset,
   input  wire logic  high_freq,
   output logic       cycle_start
);

   logic [15:0] per_cnt_q;
   logic [15:0] jit_div_q;
   logic [5:0]  tri_q;
   logic        tri_up_q;
   logic [15:0] base_per;
   logic [15:0] dev;
   logic [31:0] offs;
   logic [15:0] period;

   // ==========================================================
   // Jitter triangle, about 230 Hz
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         jit_div_q <= 16'h0000;
         tri_q     <= 6'h00;
         tri_up_q  <= 1'b1;
      end else if (jit_div_q == 16'(JIT_STEP_CYC - 1)) begin
         jit_div_q <= 16'h0000;
         if (tri_up_q && tri_q == 6'h1F) tri_up_q <= 1'b0;
         else if (!tri_up_q && tri_q == 6'h01) tri_up_q <= 1'b1;
         tri_q <= tri_up_q ? 6'(tri_q + 6'h01) : 6'(tri_q - 6'h01);
      end else begin
         jit_div_q <= 16'(jit_div_q + 16'h0001);
      end
   end

   // Period spans nominal +- deviation across the triangle  [RULE4] [RULE5]
   always_comb begin
      base_per = high_freq ? 16'(PER_HIGH) : 16'(PER_LOW);
      dev      = high_freq ? 16'(DEV_HIGH) : 16'(DEV_LOW);
      offs     = 32'(dev) * 32'(tri_q) / 32'd16;
      period   = 16'(32'(base_per) - 32'(dev) + offs);
   end

   // ==========================================================
   // Period counter
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         per_cnt_q   <= 16'h0000;
         cycle_start <= 1'b0;
      end else if (per_cnt_q >= 16'(period - 16'h0001)) begin
         per_cnt_q   <= 16'h0000;
         cycle_start <= 1'b1;
      end else begin
         per_cnt_q   <= 16'(per_cnt_q + 16'h0001);
         cycle_start <= 1'b0;
      end
   end

endmodule : ops_osc

// ===== src/ops_sequencer.sv
// Off-line converter control: supply sequencing, PWM, burst, overload restart.
// Behaviour
// RULE1: charger on at bulk start, off at turn-on
// RULE2: fault self-bias charges between levels, switch off
// RULE3: below turn-off level all activity stops; the startup charger keeps running in the charge state
// RULE4: fixed 60 or 115 kHz by variant
// RULE5: frequency jitter 4 or 8 kHz at 230 Hz
// RULE6: soft-start ramps limit every start and fault
// RULE7: PWM comparator ends on-time
// RULE8: overcurrent comparator ends on-time in parallel
// RULE9: limit reduced by set pin, default when open
// RULE10: grounded feedback selects internal compensation resistor
// RULE11: COMP saturation drives peak current to limit
// RULE12: burst holds switch off with hysteresis exit
// RULE13: burst mode uses reduced current cap
// RULE14: overload counter up on limit, down otherwise
// RULE15: trip inhibits turn-on, restart through soft-start
// RULE16: shutdown and restart repeat while overloaded
// RULE17: counter decrements to zero, never below
// RULE18: restart interval one second
// RULE19: burst current cap 145 mA
// RULE20: trip count and ramp length parameterised
// RULE21: turn-off level resets counter, burst, ramp
`timescale 1ns/1ns
module ops_sequencer
   import ops_pkg::*;
#(
   parameter int unsigned RESTART_CYCLES = RESTART_CYC,       // [RULE18]
   parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,       // [RULE20]
   parameter int unsigned OVL_LOW_COUNT  = OVL_CNT_LOW,       // [RULE20]
   parameter int unsigned OVL_HIGH_COUNT = OVL_CNT_HIGH
)
(
   input  wire logic            sys_clk,
   input  wire logic            reset,
   input  wire logic            high_freq,
   input  wire ops_supply_type  supply_pins,
   input  wire ops_sense_type   sense_pins,
   input  wire logic [7:0]      cap_set_level,
   input  wire logic            cap_set_active,
   output logic                 gate_on,
   output logic                 startup_charge_current,
   output logic                 selfbias_charge_current,
   output logic                 error_amp_enable,
   output logic                 comp_int_resistor,
   output logic [7:0]           current_cap,
   output logic                 burst_active,
   output logic                 overload_fault,
   output logic [15:0]          overload_count,
   output logic                 low_power
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   ops_supply_type supply_m_q;
   ops_supply_type supply_q;
   ops_sense_type  sense_m_q;
   ops_sense_type  sense_q;
   logic [7:0]     cap_m_q;
   logic [7:0]     cap_q;
   logic           cap_act_m_q;
   logic           cap_act_q;

   // Two flops on every external level except high_freq
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         supply_m_q  <= '0;
         supply_q    <= '0;
         sense_m_q   <= '0;
         sense_q     <= '0;
         cap_m_q     <= 8'h00;
         cap_q       <= 8'h00;
         cap_act_m_q <= 1'b0;
         cap_act_q   <= 1'b0;
      end else begin
         supply_m_q  <= supply_pins;
         supply_q    <= supply_m_q;
         sense_m_q   <= sense_pins;
         sense_q     <= sense_m_q;
         cap_m_q     <= cap_set_level;
         cap_q       <= cap_m_q;
         cap_act_m_q <= cap_set_active;
         cap_act_q   <= cap_act_m_q;
      end
   end

   // ==========================================================
   // Oscillator
   // ==========================================================
   logic cycle_start;

   ops_osc u_osc (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .high_freq   (high_freq),
      .cycle_start (cycle_start)
   );

   // ==========================================================
   // Supply state machine
   // ==========================================================
   ops_state_type state_q;
   logic [31:0]   restart_cnt_q;
   logic          ovl_trip;
   logic          uvlo;
   logic          first_start_q;

   assign uvlo = !supply_q.above_off;

   // Start-up, run, fault restart sequencing
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q       <= OPS_OFF;
         restart_cnt_q <= 32'h0000_0000;
      end else if (uvlo && state_q != OPS_OFF && state_q != OPS_CHARGE) begin
         state_q       <= OPS_OFF;                         // [RULE3]
         restart_cnt_q <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            OPS_OFF: begin
               if (supply_q.bulk_ok) state_q <= OPS_CHARGE;  // [RULE1]
            end
            OPS_CHARGE: begin
               if (supply_q.above_on) state_q <= OPS_RUN;    // [RULE1]
            end
            OPS_RUN: begin
               if (ovl_trip) begin
                  state_q       <= OPS_RESTART_WAIT;       // [RULE15]
                  restart_cnt_q <= 32'h0000_0000;
               end
            end
            OPS_RESTART_WAIT: begin
               if (restart_cnt_q >= 32'(RESTART_CYCLES - 1)) begin
                  if (supply_q.above_on || supply_q.above_cs_on)
                     state_q <= OPS_RUN;                   // [RULE15] [RULE16]
               end else begin
                  restart_cnt_q <= restart_cnt_q + 32'h0000_0001;
               end
            end
            default: state_q <= OPS_OFF;
         endcase
      end
   end

   // First start flag, cleared once switching has begun
   always_ff @(posedge sys_clk) begin
      if (reset) first_start_q <= 1'b1;
      else if (state_q == OPS_RUN) first_start_q <= 1'b0;
      else if (uvlo && state_q == OPS_OFF) first_start_q <= 1'b1;
   end

   // ==========================================================
   // Charging sources
   // ==========================================================
   // Startup source only before the first run after reset or a supply collapse; self-bias only in the
   // restart wait, and never while the switch conducts
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         startup_charge_current  <= 1'b0;
         selfbias_charge_current <= 1'b0;
      end else begin
         startup_charge_current  <= (state_q == OPS_CHARGE) && first_start_q
                                    && !supply_q.above_on;          // [RULE1]
         selfbias_charge_current <= (state_q == OPS_RESTART_WAIT)
                                    && supply_q.above_cs_on && !supply_q.above_on
                                    && !gate_on;                    // [RULE2]
      end
   end

   // ==========================================================
   // Soft-start ramp
   // ==========================================================
   logic [7:0]  ss_cap_q;
   logic [31:0] ss_div_q;

   // Ramp restarts on every entry into switching
   always_ff @(posedge sys_clk) begin
      if (reset || state_q != OPS_RUN) begin
         ss_cap_q <= SS_START_CAP;                         // [RULE6] [RULE21]
         ss_div_q <= 32'h0000_0000;
      end else if (ss_cap_q < CAP_DEFAULT) begin
         if (ss_div_q >= 32'(SS_STEP_CYCLES - 1)) begin
            ss_div_q <= 32'h0000_0000;
            ss_cap_q <= 8'(ss_cap_q + 8'h04);                // [RULE6]
         end else begin
            ss_div_q <= ss_div_q + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // Burst mode with hysteresis
   // ==========================================================
   // Enter below threshold, leave only above threshold plus hysteresis,
   // so a node resting in the band keeps the current mode
   always_ff @(posedge sys_clk) begin
      if (reset || state_q != OPS_RUN) begin
         burst_active <= 1'b0;                             // [RULE21]
      end else if (sense_q.comp_low) begin
         burst_active <= 1'b1;                             // [RULE12]
      end else if (sense_q.comp_high) begin
         burst_active <= 1'b0;                             // [RULE12]
      end
   end

   // ==========================================================
   // Active current cap selection
   // ==========================================================
   logic [7:0] user_cap;
   logic [7:0] cap_d;

   // Burst cap wins, else the lower of ramp and user limit
   always_comb begin
      user_cap = (cap_act_q && cap_q < CAP_DEFAULT) ? cap_q : CAP_DEFAULT; // [RULE9]
      if (burst_active) cap_d = BURST_CURRENT_CAP;         // [RULE13] [RULE19]
      else if (ss_cap_q < user_cap) cap_d = ss_cap_q;       // [RULE6]
      else cap_d = user_cap;
   end

   // Registered cap code for the comparator reference
   always_ff @(posedge sys_clk) begin
      if (reset) current_cap <= CAP_DEFAULT;
      else current_cap <= cap_d;
   end

   // ==========================================================
   // Feedback mode
   // ==========================================================
   // Grounded feedback pin hands the loop to the internal resistor
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         error_amp_enable  <= 1'b1;
         comp_int_resistor <= 1'b0;
      end else begin
         error_amp_enable  <= !sense_q.fb_grounded;        // [RULE10]
         comp_int_resistor <= sense_q.fb_grounded;         // [RULE10]
      end
   end

   // ==========================================================
   // PWM gate control
   // ==========================================================
   logic on_time_end;
   logic limit_hit_q;

   // Saturated COMP leaves only the cap comparator to end on-time
   assign on_time_end = (sense_q.pwm_trip && !sense_q.comp_sat)   // [RULE7] [RULE11]
                        || sense_q.oc_trip;                        // [RULE8]

   // Turn-on at cycle start; every stop condition except on-time end overrides it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gate_on <= 1'b0;
      end else if (state_q != OPS_RUN || burst_active || ovl_trip) begin
         gate_on <= 1'b0;                                  // [RULE12] [RULE15]
      end else if (cycle_start) begin
         gate_on <= 1'b1;
      end else if (on_time_end) begin
         gate_on <= 1'b0;                                  // [RULE7] [RULE8]
      end
   end

   // Remember whether this cycle hit the cap
   always_ff @(posedge sys_clk) begin
      if (reset || cycle_start) limit_hit_q <= 1'b0;
      else if (gate_on && sense_q.oc_trip) limit_hit_q <= 1'b1;
   end

   // ==========================================================
   // Overload up-down counter
   // ==========================================================
   logic [15:0] ovl_limit;

   assign ovl_limit = high_freq ? 16'(OVL_HIGH_COUNT) : 16'(OVL_LOW_COUNT);
   assign ovl_trip  = overload_count >= ovl_limit;

   // One step per switching cycle; frozen in burst so light load
   // never looks like an overload
   always_ff @(posedge sys_clk) begin
      if (reset || uvlo || state_q == OPS_RESTART_WAIT) begin
         overload_count <= 16'h0000;                       // [RULE21]
      end else if (state_q == OPS_RUN && cycle_start && !burst_active) begin
         if (limit_hit_q) overload_count <= 16'(overload_count + 16'h0001); // [RULE14]
         else if (overload_count != 16'h0000)
            overload_count <= 16'(overload_count - 16'h0001);              // [RULE17]
      end
   end

   // ==========================================================
   // Status outputs
   // ==========================================================
   // Fault and low-power flags follow the state one cycle later
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         overload_fault <= 1'b0;
         low_power      <= 1'b1;
      end else begin
         overload_fault <= (state_q == OPS_RESTART_WAIT);  // [RULE16]
         low_power      <= (state_q != OPS_RUN) || burst_active;
      end
   end

endmodule : ops_sequencer

// ===== tb/ops_seq_props.sv
// Port assertions for the converter sequencer.
`timescale 1ns/1ns
module ops_seq_props
   import ops_pkg::*;
#(
   parameter int unsigned RESTART_CYCLES = 2000
)
(
   input wire logic           sys_clk,
   input wire logic           reset,
   input wire ops_supply_type supply_pins,
   input wire ops_sense_type  sense_pins,
   input wire logic           gate_on,
   input wire logic           startup_charge_current,
   input wire logic           selfbias_charge_current,
   input wire logic           error_amp_enable,
   input wire logic           comp_int_resistor,
   input wire logic [7:0]     current_cap,
   input wire logic           burst_active,
   input wire logic           overload_fault,
   input wire logic [15:0]    overload_count
);
   // ==================
   // Fault duration
   // ==================
   logic [31:0] flt_cyc_q;

   // Counts cycles spent in the restart wait
   always_ff @(posedge sys_clk) begin
      if (reset || !overload_fault)
         flt_cyc_q <= 32'h0000_0000;
      else
         flt_cyc_q <= flt_cyc_q + 32'h0000_0001;
   end

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // ==================
   // Assertions
   // ==================
   uvlo_stop_a: assert property (
      !supply_pins.above_off [*6] |-> !gate_on && overload_count == 16'h0000 && !burst_active)
      else $error("activity below turn-off level");
   fb_ground_a: assert property (
      $stable(sense_pins.fb_grounded) [*6] |-> comp_int_resistor == sense_pins.fb_grounded
         && error_amp_enable != sense_pins.fb_grounded)
      else $error("compensation source does not follow feedback pin");
   burst_gate_a: assert property (
      burst_active [*2] |-> !gate_on) else $error("switch on during burst pause");
   burst_cap_a: assert property (
      burst_active [*2] |-> current_cap == BURST_CURRENT_CAP) else $error("burst cap wrong");
   fault_gate_a: assert property (
      overload_fault [*2] |-> !gate_on && !startup_charge_current)
      else $error("switch on during overload wait");
   count_step_a: assert property (
      overload_count != $past(overload_count) |-> overload_count == 16'h0000
         || overload_count == $past(overload_count) + 16'h0001
         || overload_count + 16'h0001 == $past(overload_count))
      else $error("overload counter jumped");
   count_floor_a: assert property (
      overload_count == 16'h0000 |=> overload_count != 16'hFFFF) else $error("counter wrapped");
   restart_wait_a: assert property (
      $fell(overload_fault) |-> flt_cyc_q >= RESTART_CYCLES) else $error("restart too early");
   restart_soft_a: assert property (
      $fell(overload_fault) |-> ##[0:4] current_cap < CAP_DEFAULT)
      else $error("restart without soft-start");
   oc_stop_a: assert property (
      $rose(sense_pins.oc_trip) |-> ##[1:4] !gate_on) else $error("overcurrent ignored");
   pwm_stop_a: assert property (
      $rose(sense_pins.pwm_trip) && !sense_pins.comp_sat |-> ##[1:4] !gate_on)
      else $error("peak current ignored");
   charger_a: assert property (
      gate_on [*2] |-> !startup_charge_current && !selfbias_charge_current)
      else $error("charger on while switching");
endmodule : ops_seq_props

bind ops_sequencer ops_seq_props #(.RESTART_CYCLES(RESTART_CYCLES)) u_props (.*);

// ===== tb/ops_plant.sv
// Plant model: switch current ramp seen through the two comparators.
`timescale 1ns/1ns
module ops_plant
   import ops_pkg::*;
#(
   parameter int unsigned PWM_TON = 20
)
(
   input  wire logic          sys_clk,
   input  wire logic          gate_on,
   input  wire logic [7:0]    oc_at,
   input  wire ops_sense_type loop_pins,
   output ops_sense_type      sense_pins
);
   logic [7:0] on_cyc_q = 8'h00;

   // Current grows only while the switch conducts
   always_ff @(posedge sys_clk) begin
      if (!gate_on)
         on_cyc_q <= 8'h00;
      else if (on_cyc_q != 8'hFF)
         on_cyc_q <= on_cyc_q + 8'h01;
   end

   // Comparators fall with the current once the switch opens
   always_comb begin
      sense_pins          = loop_pins;
      sense_pins.pwm_trip = gate_on && on_cyc_q >= PWM_TON;
      sense_pins.oc_trip  = gate_on && oc_at != 8'h00 && on_cyc_q >= oc_at;
   end
endmodule : ops_plant

// ===== tb/ops_sequencer_test.sv
// Self-checking bench for the converter sequencer and its plant model.
`timescale 1ns/1ns
module ops_sequencer_test
   import ops_pkg::*;
;
   localparam int unsigned RST_CYC  = 2000;
   localparam int          ON_LO[3] = '{8, 20, 40};

   logic           sys_clk, reset, high_freq, cap_set_active, act;
   logic [7:0]     cap_set_level, oc_at, lvl, current_cap;
   ops_supply_type supply_pins;
   ops_sense_type  loop_pins, sense_pins;
   logic           gate_on, startup_charge_current, selfbias_charge_current;
   logic           error_amp_enable, comp_int_resistor, burst_active, overload_fault;
   logic           low_power;
   logic [15:0]    overload_count;
   int             err_total, compares, seed, n, i;

   ops_sequencer #(.RESTART_CYCLES(RST_CYC), .SS_STEP_CYCLES(10), .OVL_LOW_COUNT(5),
      .OVL_HIGH_COUNT(5)) u_dut (.sys_clk(sys_clk), .reset(reset), .high_freq(high_freq),
      .supply_pins(supply_pins), .sense_pins(sense_pins), .cap_set_level(cap_set_level),
      .cap_set_active(cap_set_active), .gate_on(gate_on),
      .startup_charge_current(startup_charge_current),
      .selfbias_charge_current(selfbias_charge_current), .error_amp_enable(error_amp_enable),
      .comp_int_resistor(comp_int_resistor), .current_cap(current_cap),
      .burst_active(burst_active), .overload_fault(overload_fault),
      .overload_count(overload_count), .low_power(low_power));

   ops_plant u_plant (.sys_clk(sys_clk), .gate_on(gate_on), .oc_at(oc_at),
      .loop_pins(loop_pins), .sense_pins(sense_pins));

   // ==================
   // Tasks
   // ==================
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : tick

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      compares++;
      if ($isunknown(got) || got < lo || got > hi) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : rng

   function automatic logic [7:0] exp_cap(input logic a, input logic [7:0] l);
      return (a && l < CAP_DEFAULT) ? l : CAP_DEFAULT;
   endfunction : exp_cap

   task automatic done(input string s);
      $display("test %s ended, mismatches %0d", s, err_total);
   endtask : done

   // Next turn-on, cycles waited left in n
   task automatic rise();
      for (n = 0; n < 9000 && gate_on !== 1'b0; n++) tick(1);
      for (; n < 9000 && gate_on !== 1'b1; n++) tick(1);
      if (n >= 9000) chk(gate_on, 1'b1);
   endtask : rise

   // Reset, then bulk and supply levels in order
   task automatic boot(input logic f);
      reset       <= 1'b1;
      high_freq   <= f;
      supply_pins <= 4'h0;
      tick(20);
      reset       <= 1'b0;
      tick(4);
      supply_pins <= 4'h8;
      tick(8);
      chk(startup_charge_current, 1'b1);
      chk(gate_on, 1'b0);
      supply_pins <= 4'hF;
      tick(10);
      rng(current_cap, SS_START_CAP, CAP_DEFAULT - 8'h01);
      tick(300);
      chk(current_cap, CAP_DEFAULT);
      rise();
      chk(startup_charge_current, 1'b0);
      done("boot");
   endtask : boot

   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // ==================
   // Clock and watchdog
   // ==================
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (95000) @(posedge sys_clk);
      err_total++;
      wrap_up();
   end

   // ==================
   // Main sequence
   // ==================
   initial begin
      seed           = 55771;
      err_total      = 0;
      compares       = 0;
      reset          = 1'b1;
      high_freq      = 1'b0;
      supply_pins    = 4'h0;
      loop_pins      = 6'h04;
      oc_at          = 8'h00;
      cap_set_level  = 8'h00;
      cap_set_active = 1'b0;
      boot(1'b0);
      for (i = 0; i < 3; i++) begin
         rise();
         rng(n[15:0], PER_LOW - DEV_LOW - 4, PER_LOW + DEV_LOW + 4);
      end
      // Limit-set pin: corners around the default, then random codes
      for (i = 0; i < 8; i++) begin
         lvl = (i < 3) ? 8'h45 + 8'(i) : 8'($random(seed));
         act = (i < 3) ? 1'b1 : 1'($random(seed));
         cap_set_level  <= lvl;
         cap_set_active <= act;
         tick(6);
         chk(current_cap, exp_cap(act, lvl));
      end
      cap_set_active <= 1'b0;
      loop_pins      <= 6'h05;
      tick(6);
      chk(comp_int_resistor, 1'b1);
      chk(error_amp_enable, 1'b0);
      done("limit_and_feedback");
      // On-time ended by overcurrent, by peak current, and in saturation
      for (i = 0; i < 3; i++) begin
         loop_pins <= (i == 2) ? 6'h06 : 6'h04;
         oc_at     <= (i == 0) ? 8'h08 : 8'h28;
         rise();
         rise();
         for (n = 0; n < 255 && gate_on === 1'b1; n++) tick(1);
         rng(n[15:0], ON_LO[i], ON_LO[i] + 6);
      end
      done("on_time");
      // Persistent overload trips twice, with self-bias during the wait
      loop_pins <= 6'h04;
      oc_at     <= 8'h08;
      for (i = 0; i < 2; i++) begin
         for (n = 0; n < 20000 && overload_fault !== 1'b1; n++) tick(1);
         chk(overload_fault, 1'b1);
         supply_pins <= 4'hB;
         tick(8);
         chk(selfbias_charge_current, 1'b1);
         supply_pins <= 4'hF;
         for (n = 0; n < 3000 && overload_fault !== 1'b0; n++) tick(1);
         rng(n[15:0], RST_CYC - 30, RST_CYC + 10);
      end
      for (n = 0; n < 9000 && overload_count !== 16'h0002; n++) tick(1);
      oc_at <= 8'h00;
      for (n = 0; n < 12000 && overload_count !== 16'h0000; n++) tick(1);
      tick(2 * PER_LOW);
      chk(overload_count, 16'h0000);
      chk(overload_fault, 1'b0);
      done("overload");
      // Burst entry, hysteresis band, exit
      loop_pins <= 6'h08;
      tick(8);
      chk(burst_active, 1'b1);
      chk(current_cap, BURST_CURRENT_CAP);
      chk(low_power, 1'b1);
      loop_pins <= 6'h00;
      for (n = 0; n < 2 * PER_LOW && gate_on !== 1'b1; n++) tick(1);
      chk(gate_on, 1'b0);
      loop_pins <= 6'h04;
      rise();
      chk(burst_active, 1'b0);
      done("burst");
      // Supply collapse with a non-zero counter
      oc_at <= 8'h08;
      rise();
      rise();
      supply_pins <= 4'h0;
      tick(8);
      chk(gate_on, 1'b0);
      chk(overload_count, 16'h0000);
      oc_at <= 8'h00;
      boot(1'b1);
      rise();
      rng(n[15:0], PER_HIGH - DEV_HIGH - 4, PER_HIGH + DEV_HIGH + 4);
      done("uvlo_and_high");
      wrap_up();
   end
endmodule : ops_sequencer_test
